// file: design/agc_cfg_consts.svh
`ifndef AGC_CFG_CONSTS_SVH
`define AGC_CFG_CONSTS_SVH

// ****************************************************************
// Register addresses (page 0 register numbers)
// ****************************************************************
`define ADDR_ENABLE_TARGET   8'h56
`define ADDR_HYST_NOISE      8'h57
`define ADDR_MAX_GAIN        8'h58
`define ADDR_ATTACK_TIME     8'h59

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_ENABLE_TARGET    8'h00
`define RST_HYST_NOISE       8'h00
`define RST_MAX_GAIN         8'h7F
`define RST_ATTACK_TIME      8'h00
`define RDATA_UNMAPPED       8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define ENABLE_BIT           7
`define TARGET_HI            6
`define TARGET_LO            4
`define HYST_HI              7
`define HYST_LO              6
`define NOISE_HI             5
`define NOISE_LO             1
`define MAX_GAIN_HI          6
`define MAX_GAIN_LO          0
`define ATK_BASE_HI          7
`define ATK_BASE_LO          3
`define ATK_MUL_HI           2
`define ATK_MUL_LO           0

// ****************************************************************
// Decoding constants
// ****************************************************************
`define HYST_OFF_CODE        2'h3
`define NOISE_OFF_CODE       5'h00
`define NOISE_BASE_DB        7'h1C
`define MAX_GAIN_TOP_CODE    7'h77
`define ATK_UNIT_SHIFT       5

`endif

// file: design/agc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface agc_cfg_if;
   import agc_cfg_pkg::*;

   reg_byte_t   enable_target;
   reg_byte_t   hyst_noise;
   reg_byte_t   max_gain;
   reg_byte_t   attack_time;
   logic        agc_run;
   logic [5:0]  target_half_db;
   logic        hyst_en;
   logic [2:0]  hyst_db;
   logic        noise_det_en;
   logic [6:0]  noise_thresh_db;
   logic [6:0]  max_gain_half_db;
   logic [17:0] attack_periods;

   modport regs (
      output enable_target, hyst_noise, max_gain, attack_time,
      input  agc_run, target_half_db, hyst_en, hyst_db, noise_det_en,
      input  noise_thresh_db, max_gain_half_db, attack_periods
   );

   modport dec (
      input  enable_target, hyst_noise, max_gain, attack_time,
      output agc_run, target_half_db, hyst_en, hyst_db, noise_det_en,
      output noise_thresh_db, max_gain_half_db, attack_periods
   );

endinterface

`default_nettype wire

// file: design/agc_cfg_pkg.sv
package agc_cfg_pkg;

   typedef logic [7:0] reg_byte_t;

   typedef struct packed {
      reg_byte_t   enable_target;
      reg_byte_t   hyst_noise;
      reg_byte_t   max_gain;
      reg_byte_t   attack_time;
      reg_byte_t   rdata;
      logic        rd_valid;
      logic        agc_run;
      logic [5:0]  target_half_db;
      logic        hyst_en;
      logic [2:0]  hyst_db;
      logic        noise_det_en;
      logic [6:0]  noise_thresh_db;
      logic [6:0]  max_gain_half_db;
      logic [17:0] attack_periods;
   } cfg_state_s;

endpackage

// file: design/agc_config_registers.sv
// Function
// - Gain control runs only while enable bit 7 of the first register is set.
// - Target level field bits 6..4 selects -5.5 down to -24 dB.
// - Hysteresis field bits 7..6 codes 0..2 give 1, 2, 4 dB.
// - Hysteresis code 3 disables hysteresis entirely.
// - Noise threshold code zero disables noise and silence detection.
// - Noise threshold is -30 dB at code 1, minus 2 dB per step.
// - Applied gain is limited to max-gain code times 0.5 dB; codes above 0x77 give 59.5 dB.
// - Base attack time is (2N+1) times 32 sample periods.
// - Attack time is multiplied by two to the power of bits 2..0.
`timescale 1ns/1ps
`default_nettype none
`include "agc_cfg_consts.svh"

module agc_config_registers
   import agc_cfg_pkg::*;
(
   input  wire logic        core_clk,          // Core clock, 100 MHz
   input  wire logic        rst_n,             // Synchronous reset, active low
   input  wire logic        reg_wr,            // Register write strobe
   input  wire logic        reg_rd,            // Register read strobe
   input  wire logic [7:0]  reg_addr,          // Page 0 register number
   input  wire logic [7:0]  reg_wdata,         // Write data
   output logic      [7:0]  reg_rdata,         // Read data, held until next read
   output logic             reg_rd_valid,      // Read data valid pulse
   output logic             agc_run,           // Gain loop enable
   output logic      [5:0]  target_half_db,    // Target level magnitude, 0.5 dB units
   output logic             hyst_en,           // Hysteresis in use
   output logic      [2:0]  hyst_db,           // Hysteresis in dB
   output logic             noise_det_en,      // Noise and silence detection on
   output logic      [6:0]  noise_thresh_db,   // Noise threshold magnitude in dB
   output logic      [6:0]  max_gain_half_db,  // Gain ceiling, 0.5 dB units
   output logic      [17:0] attack_periods     // Attack time in ADC sample periods
);

   // ****************************************************************
   // Address decode, shared by the write and read paths
   // ****************************************************************
   function automatic logic [2:0] reg_select(input logic [7:0] addr);
      case (addr)
         `ADDR_ENABLE_TARGET: reg_select = 3'h1;
         `ADDR_HYST_NOISE:    reg_select = 3'h2;
         `ADDR_MAX_GAIN:      reg_select = 3'h3;
         `ADDR_ATTACK_TIME:   reg_select = 3'h4;
         default:             reg_select = 3'h0;
      endcase
   endfunction

   cfg_state_s st_r;
   cfg_state_s st_nxt;
   logic [2:0] wr_sel;
   logic [2:0] rd_sel;

   agc_cfg_if cfg ();

   assign cfg.enable_target = st_r.enable_target;
   assign cfg.hyst_noise    = st_r.hyst_noise;
   assign cfg.max_gain      = st_r.max_gain;
   assign cfg.attack_time   = st_r.attack_time;

   agc_setting_decode u_decode (
      .cfg (cfg.dec)
   );

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      wr_sel = reg_select(reg_addr);
      rd_sel = reg_select(reg_addr);

      // Reserved bits are stored as written; the host keeps them zero.
      if (reg_wr) begin
         case (wr_sel)
            3'h1:    st_nxt.enable_target = reg_wdata;
            3'h2:    st_nxt.hyst_noise    = reg_wdata;
            3'h3:    st_nxt.max_gain      = reg_wdata;
            3'h4:    st_nxt.attack_time   = reg_wdata;
            default: st_nxt.enable_target = st_r.enable_target;
         endcase
      end

      // A read in the same cycle as a write returns the value before the write.
      st_nxt.rd_valid = reg_rd;
      if (reg_rd) begin
         case (rd_sel)
            3'h1:    st_nxt.rdata = st_r.enable_target;
            3'h2:    st_nxt.rdata = st_r.hyst_noise;
            3'h3:    st_nxt.rdata = st_r.max_gain;
            3'h4:    st_nxt.rdata = st_r.attack_time;
            default: st_nxt.rdata = `RDATA_UNMAPPED;
         endcase
      end

      // Decoded settings are registered so the gain loop sees glitch-free levels.
      st_nxt.agc_run          = cfg.agc_run;
      st_nxt.target_half_db   = cfg.target_half_db;
      st_nxt.hyst_en          = cfg.hyst_en;
      st_nxt.hyst_db          = cfg.hyst_db;
      st_nxt.noise_det_en     = cfg.noise_det_en;
      st_nxt.noise_thresh_db  = cfg.noise_thresh_db;
      st_nxt.max_gain_half_db = cfg.max_gain_half_db;
      st_nxt.attack_periods   = cfg.attack_periods;

      if (!rst_n) begin
         st_nxt                  = '0;
         st_nxt.enable_target    = `RST_ENABLE_TARGET;
         st_nxt.hyst_noise       = `RST_HYST_NOISE;
         st_nxt.max_gain         = `RST_MAX_GAIN;
         st_nxt.attack_time      = `RST_ATTACK_TIME;
         st_nxt.rdata            = `RDATA_UNMAPPED;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      st_r <= st_nxt;
   end

   assign reg_rdata        = st_r.rdata;
   assign reg_rd_valid     = st_r.rd_valid;
   assign agc_run          = st_r.agc_run;
   assign target_half_db   = st_r.target_half_db;
   assign hyst_en          = st_r.hyst_en;
   assign hyst_db          = st_r.hyst_db;
   assign noise_det_en     = st_r.noise_det_en;
   assign noise_thresh_db  = st_r.noise_thresh_db;
   assign max_gain_half_db = st_r.max_gain_half_db;
   assign attack_periods   = st_r.attack_periods;

endmodule

`default_nettype wire

// file: design/agc_setting_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "agc_cfg_consts.svh"

module agc_setting_decode
   import agc_cfg_pkg::*;
(
   agc_cfg_if.dec cfg   // Raw register bytes in, decoded settings out
);

   // ****************************************************************
   // Lookup of the target level, as a magnitude in 0.5 dB steps
   // ****************************************************************
   function automatic logic [5:0] target_lookup(input logic [2:0] code);
      case (code)
         3'h0:    target_lookup = 6'h0B;
         3'h1:    target_lookup = 6'h10;
         3'h2:    target_lookup = 6'h14;
         3'h3:    target_lookup = 6'h18;
         3'h4:    target_lookup = 6'h1C;
         3'h5:    target_lookup = 6'h22;
         3'h6:    target_lookup = 6'h28;
         default: target_lookup = 6'h30;
      endcase
   endfunction

   logic [1:0] hyst_code;
   logic [4:0] noise_code;
   logic [6:0] gain_code;
   logic [4:0] atk_base;
   logic [2:0] atk_mul;

   always_comb begin
      hyst_code  = cfg.hyst_noise[`HYST_HI:`HYST_LO];
      noise_code = cfg.hyst_noise[`NOISE_HI:`NOISE_LO];
      gain_code  = cfg.max_gain[`MAX_GAIN_HI:`MAX_GAIN_LO];
      atk_base   = cfg.attack_time[`ATK_BASE_HI:`ATK_BASE_LO];
      atk_mul    = cfg.attack_time[`ATK_MUL_HI:`ATK_MUL_LO];

      cfg.agc_run        = cfg.enable_target[`ENABLE_BIT];
      cfg.target_half_db = target_lookup(cfg.enable_target[`TARGET_HI:`TARGET_LO]);

      // Code 3 turns hysteresis off; the dB figure is then zero as well.
      cfg.hyst_en = (hyst_code != `HYST_OFF_CODE);
      case (hyst_code)
         2'h0:    cfg.hyst_db = 3'h1;
         2'h1:    cfg.hyst_db = 3'h2;
         2'h2:    cfg.hyst_db = 3'h4;
         default: cfg.hyst_db = 3'h0;
      endcase

      cfg.noise_det_en = (noise_code != `NOISE_OFF_CODE);
      if (cfg.noise_det_en) begin
         cfg.noise_thresh_db = `NOISE_BASE_DB + {1'b0, noise_code, 1'b0};
      end else begin
         cfg.noise_thresh_db = 7'h00;
      end

      // Reserved gain codes are clamped so the loop never sees a gain above 59.5 dB.
      if (gain_code > `MAX_GAIN_TOP_CODE) begin
         cfg.max_gain_half_db = `MAX_GAIN_TOP_CODE;
      end else begin
         cfg.max_gain_half_db = gain_code;
      end

      cfg.attack_periods = 18'({12'h000, atk_base, 1'b1})
                           << (`ATK_UNIT_SHIFT + atk_mul);
   end

endmodule

`default_nettype wire

// file: verification/agc_config_registers_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module agc_config_registers_asserts (
   input wire logic        core_clk,         // Clock
   input wire logic        rst_n,            // Reset
   input wire logic        reg_wr,           // Write
   input wire logic        reg_rd,           // Read
   input wire logic [7:0]  reg_addr,         // Address
   input wire logic [7:0]  reg_wdata,        // Write data
   input wire logic [7:0]  reg_rdata,        // Read data
   input wire logic        reg_rd_valid,     // Read valid
   input wire logic        agc_run,          // Enable
   input wire logic [5:0]  target_half_db,   // Target
   input wire logic [2:0]  hyst_db,          // Hysteresis
   input wire logic [6:0]  noise_thresh_db,  // Noise level
   input wire logic [6:0]  max_gain_half_db, // Gain ceiling
   input wire logic [17:0] attack_periods    // Attack time
);
   localparam logic [5:0] TGT [8] = '{6'h0B, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h22, 6'h28, 6'h30};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Decoded outputs lag the write edge by two edges.
   chk_enable_follow: assert property (reg_wr && reg_addr == 8'h56 |->
      ##2 agc_run == $past(reg_wdata[7], 2)) else $error("enable mismatch");
   chk_target_map: assert property (reg_wr && reg_addr == 8'h56 |->
      ##2 target_half_db == TGT[$past(reg_wdata[6:4], 2)]) else $error("target mismatch");
   chk_hyst_step: assert property (reg_wr && reg_addr == 8'h57 && reg_wdata[7:6] != 2'h3 |->
      ##2 hyst_db == (3'h1 << $past(reg_wdata[7:6], 2))) else $error("hysteresis mismatch");
   chk_noise_level: assert property (reg_wr && reg_addr == 8'h57 &&
      reg_wdata[5:1] != 5'h0 |-> ##2 noise_thresh_db == 7'h1C + {$past(reg_wdata[5:1], 2), 1'b0})
      else $error("noise mismatch");
   chk_gain_limit: assert property (reg_wr && reg_addr == 8'h58 &&
      reg_wdata[6:0] <= 7'h77 |-> ##2 max_gain_half_db == $past(reg_wdata[6:0], 2))
      else $error("gain ceiling mismatch");
   chk_attack_time: assert property (reg_wr && reg_addr == 8'h59 |-> ##2 attack_periods ==
      (18'({$past(reg_wdata[7:3], 2), 1'b1}) << 5) << $past(reg_wdata[2:0], 2))
      else $error("attack time mismatch");
   chk_read_valid: assert property (reg_rd |=> reg_rd_valid)
      else $error("read valid missing");
   chk_read_hold: assert property (!reg_rd |=> !reg_rd_valid && $stable(reg_rdata))
      else $error("read data not held");
   chk_read_back: assert property (reg_wr ##1 reg_rd && !reg_wr && $stable(reg_addr) &&
      reg_addr inside {[8'h56:8'h59]} |=> reg_rdata == $past(reg_wdata, 2))
      else $error("readback");
endmodule
bind agc_config_registers agc_config_registers_asserts i_chk (.core_clk, .rst_n, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .agc_run, .target_half_db, .hyst_db,
   .noise_thresh_db, .max_gain_half_db, .attack_periods);
`default_nettype wire

// file: verification/agc_config_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module agc_config_registers_test;
   localparam logic [5:0] TGT [8] = '{6'h0B, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h22, 6'h28, 6'h30};
   logic        core_clk, rst_n, reg_wr, reg_rd, reg_rd_valid, agc_run, hyst_en, noise_det_en;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rnd;
   logic [5:0]  target_half_db;
   logic [2:0]  hyst_db;
   logic [6:0]  noise_thresh_db, max_gain_half_db;
   logic [17:0] attack_periods;
   logic [7:0]  sh [4];
   int          err_total, comparisons;
   agc_config_registers i_dut (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_rd_valid, .agc_run, .target_half_db, .hyst_en, .hyst_db, .noise_det_en,
      .noise_thresh_db, .max_gain_half_db, .attack_periods);
   agc_host_model i_host (.core_clk, .reg_rdata, .reg_rd_valid, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata);
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   function automatic logic [43:0] dec(input logic [7:0] r0, r1, r2, r3);
      logic [4:0] nc;
      logic [1:0] hc;
      nc = r1[5:1];
      hc = r1[7:6];
      dec = {r0[7], TGT[r0[6:4]], hc != 2'h3, (hc == 2'h3) ? 3'h0 : 3'h1 << hc, nc != 5'h00,
             (nc == 5'h00) ? 7'h00 : 7'h1C + {nc, 1'b0}, (r2[6:0] > 7'h77) ? 7'h77 : r2[6:0],
             (18'({r3[7:3], 1'b1}) << 5) << r3[2:0]};
   endfunction
   task automatic op(input logic [7:0] a, input logic [7:0] d, input logic w);
      logic [7:0]  q, wv;
      logic        v, m;
      logic [43:0] seen;
      m = a >= 8'h56 && a <= 8'h59;
      i_host.xfer(w, a, d, wv, q, v);
      if (w && m) sh[2'(a - 8'h56)] = wv;
      `CHK("read_valid", 1'b1, v)
      `CHK("read_data", m ? sh[2'(a - 8'h56)] : 8'h00, q)
      seen = {agc_run, target_half_db, hyst_en, hyst_db, noise_det_en, noise_thresh_db,
              max_gain_half_db, attack_periods};
      `CHK("decoded", dec(sh[0], sh[1], sh[2], sh[3]), seen)
   endtask
   task automatic do_reset();
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      sh = '{8'h00, 8'h00, 8'h7F, 8'h00};
      for (int i = 0; i < 4; i++) op(8'h56 + 8'(i), 8'h00, 1'b0);
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      stop_test();
   end
   initial begin
      rst_n = 1'b0;
      err_total = 0;
      comparisons = 0;
      rnd = 8'h5C;
      do_reset();
      for (int i = 0; i < 8; i++) op(8'h56, {i[0], i[2:0], 4'hF}, 1'b1);
      for (int i = 0; i < 4; i++) op(8'h57, {i[1:0], 6'h3F}, 1'b1);
      op(8'h57, 8'h02, 1'b1);
      op(8'h57, 8'h00, 1'b1);
      op(8'h58, 8'hFF, 1'b1);
      op(8'h58, 8'h00, 1'b1);
      op(8'h59, 8'hFF, 1'b1);
      op(8'h5A, 8'hAA, 1'b1);
      for (int i = 0; i < 60; i++) begin
         rnd = lfsr(rnd);
         op(8'h55 + {5'h00, rnd[2:0]}, lfsr(rnd), rnd[5] | rnd[6]);
      end
      do_reset();
      stop_test();
   end
endmodule
`default_nettype wire

// file: verification/agc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module agc_host_model (
   input  wire logic       core_clk,     // Clock
   input  wire logic [7:0] reg_rdata,    // Read data
   input  wire logic       reg_rd_valid, // Read valid
   output var  logic       reg_wr,       // Write strobe
   output var  logic       reg_rd,       // Read strobe
   output var  logic [7:0] reg_addr,     // Address
   output var  logic [7:0] reg_wdata     // Write data
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
      case (a)
         8'h56: legal = d & 8'hF0;
         8'h57: legal = d & 8'hFE;
         8'h58: legal = (d[6:0] > 7'h77) ? 8'h77 : {1'b0, d[6:0]};
         default: legal = d;
      endcase
   endfunction
   // Optional write, then a read of the same place; the bus goes to the inverse once released.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] wv, output logic [7:0] q, output logic v);
      wv = legal(a, d);
      @(posedge core_clk);
      reg_wr <= w;
      reg_addr <= a;
      reg_wdata <= wv;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~wv;
      #1;
      q = reg_rdata;
      v = reg_rd_valid;
   endtask
endmodule
`default_nettype wire
